/* scrg_pkg.sv */
// Package of offsets, field positions and types for the scaler control/status registers
package scrg_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_STATUS_OFS = 8'h00;
  localparam logic [7:0] IDENT_REV_OFS = 8'h04;
  localparam logic [7:0] IRQ_CONFIG_OFS = 8'h08;

  // ----------------------------------------------------------------
  // Control/status field positions
  // ----------------------------------------------------------------
  localparam int CLR_SHIFT = 16;
  localparam int LED_BIT = 0;
  localparam int PULSE25_BIT = 4;
  localparam int TESTMODE_BIT = 5;
  localparam int REFPULSE_BIT = 6;
  localparam int SCALER_ACT_BIT = 16;
  localparam int MCS_ACT_BIT = 18;
  localparam int MEMTEST_BIT = 23;
  localparam int ARMED_BIT = 24;
  localparam int HISTO_BIT = 25;
  localparam int OVERFLOW_BIT = 27;
  localparam int EXT_IN_LSB = 28;
  localparam int EXT_LATCH_LSB = 30;

  // ----------------------------------------------------------------
  // Interrupt configuration fields and reset values
  // ----------------------------------------------------------------
  localparam int IRQ_ROAK_BIT = 12;
  localparam int IRQ_EN_BIT = 11;
  localparam int IRQ_LVL_LSB = 8;
  localparam logic [12:0] IRQ_CONFIG_RST = 13'h0000;
  localparam logic [3:0] CTRL_RST = 4'h0;
  localparam logic [31:0] READ_ZERO = 32'h00000000;

  // Control functions held by the J/K register
  typedef struct packed {
    logic ref_pulser;
    logic test_mode;
    logic pulse25;
    logic led;
  } scrg_ctrl_t;

  // Interrupt configuration fields
  typedef struct packed {
    logic roak;
    logic enable;
    logic [2:0] level;
    logic [7:0] vector;
  } scrg_irqcfg_t;

endpackage : scrg_pkg

/* scrg_regs.sv */
// Control/status, identification and interrupt configuration registers of the scaler
`timescale 1ns/1ps
`default_nettype none
module scrg_regs #(
  parameter logic [15:0] MODULE_ID = 16'h1234,  // Arbitrary value
  parameter logic [7:0] MAJOR_REV = 8'h0A,      // Arbitrary value
  parameter logic [7:0] MINOR_REV = 8'h00,      // Arbitrary value
  parameter int CHANNELS = 32
) (
  // Clock and reset
  input wire logic CLOCK_IN,
  input wire logic SRST_IN,
  // Register access
  input wire logic [7:0] ADDR_IN,
  input wire logic WR_IN,
  input wire logic RD_IN,
  input wire logic [31:0] WDATA_IN,
  output logic [31:0] RDATA_OUT,
  output logic RVALID_OUT,
  // Interrupt acknowledge
  input wire logic IACK_IN,
  output logic [7:0] IACK_VECTOR_OUT,
  output logic IACK_VALID_OUT,
  // Status from the acquisition core
  input wire logic SCALER_ACTIVE_IN,
  input wire logic MCS_ACTIVE_IN,
  input wire logic MEMTEST_IN,
  input wire logic ARMED_IN,
  input wire logic HISTOGRAM_SCALER_OPERATION_IN,
  input wire logic OVERFLOW_IN,
  input wire logic [1:0] EXT_INPUT_IN,
  input wire logic [1:0] EXT_LATCH_IN,
  // Test pulse sources
  input wire logic KEY_TEST_PULSE_IN,
  input wire logic PULSE25_IN,
  input wire logic REF_PULSE_IN,
  input wire logic [CHANNELS-1:0] INHIBIT_IN,
  input wire logic [CHANNELS-1:0] TEST_MASK_IN,
  // Control outputs
  output logic LED_OUT,
  output logic [CHANNELS-1:0] COUNT_PULSE_OUT,
  output logic IRQ_ENABLE_OUT,
  output logic [2:0] IRQ_LEVEL_OUT,
  output logic IRQ_ROAK_OUT
);

  // ----------------------------------------------------------------
  // Synchronisers for external levels
  // ----------------------------------------------------------------
  // Pins arrive from outside the clock domain
  logic [1:0] ext_in_s1_r;
  logic [1:0] ext_in_s2_r;
  logic [1:0] ext_lat_s1_r;
  logic [1:0] ext_lat_s2_r;
  logic pulse25_s1_r;
  logic pulse25_s2_r;
  logic ref_s1_r;
  logic ref_s2_r;

  always_ff @(posedge CLOCK_IN)
  begin
    if (SRST_IN)
    begin
      ext_in_s1_r <= 2'h0;
      ext_in_s2_r <= 2'h0;
      ext_lat_s1_r <= 2'h0;
      ext_lat_s2_r <= 2'h0;
      pulse25_s1_r <= 1'b0;
      pulse25_s2_r <= 1'b0;
      ref_s1_r <= 1'b0;
      ref_s2_r <= 1'b0;
    end
    else
    begin
      ext_in_s1_r <= EXT_INPUT_IN;
      ext_in_s2_r <= ext_in_s1_r;
      ext_lat_s1_r <= EXT_LATCH_IN;
      ext_lat_s2_r <= ext_lat_s1_r;
      pulse25_s1_r <= PULSE25_IN;
      pulse25_s2_r <= pulse25_s1_r;
      ref_s1_r <= REF_PULSE_IN;
      ref_s2_r <= ref_s1_r;
    end
  end

  // ----------------------------------------------------------------
  // J/K control register
  // ----------------------------------------------------------------
  scrg_pkg::scrg_ctrl_t ctrl_r;
  scrg_pkg::scrg_ctrl_t ctrl_nxt;
  logic wr_ctrl;

  assign wr_ctrl = WR_IN && (ADDR_IN == scrg_pkg::CTRL_STATUS_OFS);

  // Set wins over clear if both are written; software must avoid that case
  function automatic logic jk(input logic cur, input logic set, input logic clr);
    jk = set ? 1'b1 : (clr ? 1'b0 : cur);
  endfunction : jk

  always_comb
  begin
    ctrl_nxt = ctrl_r;
    if (wr_ctrl)
    begin
      ctrl_nxt.led = jk(ctrl_r.led, WDATA_IN[scrg_pkg::LED_BIT],
        WDATA_IN[scrg_pkg::LED_BIT + scrg_pkg::CLR_SHIFT]);
      ctrl_nxt.pulse25 = jk(ctrl_r.pulse25, WDATA_IN[scrg_pkg::PULSE25_BIT],
        WDATA_IN[scrg_pkg::PULSE25_BIT + scrg_pkg::CLR_SHIFT]);
      ctrl_nxt.test_mode = jk(ctrl_r.test_mode, WDATA_IN[scrg_pkg::TESTMODE_BIT],
        WDATA_IN[scrg_pkg::TESTMODE_BIT + scrg_pkg::CLR_SHIFT]);
      ctrl_nxt.ref_pulser = jk(ctrl_r.ref_pulser, WDATA_IN[scrg_pkg::REFPULSE_BIT],
        WDATA_IN[scrg_pkg::REFPULSE_BIT + scrg_pkg::CLR_SHIFT]);
    end
  end

  always_ff @(posedge CLOCK_IN)
  begin
    if (SRST_IN)
      ctrl_r <= scrg_pkg::scrg_ctrl_t'(scrg_pkg::CTRL_RST);
    else
      ctrl_r <= ctrl_nxt;
  end

  // ----------------------------------------------------------------
  // Interrupt configuration register
  // ----------------------------------------------------------------
  scrg_pkg::scrg_irqcfg_t irqcfg_r;

  always_ff @(posedge CLOCK_IN)
  begin
    if (SRST_IN)
      irqcfg_r <= scrg_pkg::scrg_irqcfg_t'(scrg_pkg::IRQ_CONFIG_RST);
    else if (WR_IN && (ADDR_IN == scrg_pkg::IRQ_CONFIG_OFS))
      irqcfg_r <= scrg_pkg::scrg_irqcfg_t'(WDATA_IN[scrg_pkg::IRQ_ROAK_BIT:0]);
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  logic [31:0] status_word;

  always_comb
  begin
    status_word = scrg_pkg::READ_ZERO;
    status_word[scrg_pkg::LED_BIT] = ctrl_r.led;
    status_word[scrg_pkg::PULSE25_BIT] = ctrl_r.pulse25;
    status_word[scrg_pkg::TESTMODE_BIT] = ctrl_r.test_mode;
    status_word[scrg_pkg::REFPULSE_BIT] = ctrl_r.ref_pulser;
    status_word[scrg_pkg::SCALER_ACT_BIT] = SCALER_ACTIVE_IN;
    status_word[scrg_pkg::MCS_ACT_BIT] = MCS_ACTIVE_IN;
    status_word[scrg_pkg::MEMTEST_BIT] = MEMTEST_IN;
    status_word[scrg_pkg::ARMED_BIT] = ARMED_IN;
    status_word[scrg_pkg::HISTO_BIT] = HISTOGRAM_SCALER_OPERATION_IN;
    status_word[scrg_pkg::OVERFLOW_BIT] = OVERFLOW_IN;
    status_word[scrg_pkg::EXT_IN_LSB +: 2] = ext_in_s2_r;
    status_word[scrg_pkg::EXT_LATCH_LSB +: 2] = ext_lat_s2_r;
  end

  // Unmapped offsets read as zero; reads have one cycle latency
  always_ff @(posedge CLOCK_IN)
  begin
    if (SRST_IN)
    begin
      RDATA_OUT <= scrg_pkg::READ_ZERO;
      RVALID_OUT <= 1'b0;
    end
    else
    begin
      RVALID_OUT <= RD_IN;
      if (!RD_IN)
        RDATA_OUT <= scrg_pkg::READ_ZERO;
      else if (ADDR_IN == scrg_pkg::CTRL_STATUS_OFS)
        RDATA_OUT <= status_word;
      else if (ADDR_IN == scrg_pkg::IDENT_REV_OFS)
        RDATA_OUT <= {MODULE_ID, MAJOR_REV, MINOR_REV};
      else if (ADDR_IN == scrg_pkg::IRQ_CONFIG_OFS)
        RDATA_OUT <= {19'h00000, irqcfg_r};
      else
        RDATA_OUT <= scrg_pkg::READ_ZERO;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt acknowledge and configuration outputs
  // ----------------------------------------------------------------
  // Only the configuration side of the eight sources lives here
  always_ff @(posedge CLOCK_IN)
  begin
    if (SRST_IN)
    begin
      IACK_VECTOR_OUT <= 8'h00;
      IACK_VALID_OUT <= 1'b0;
      IRQ_ENABLE_OUT <= 1'b0;
      IRQ_LEVEL_OUT <= 3'h0;
      IRQ_ROAK_OUT <= 1'b0;
    end
    else
    begin
      IACK_VALID_OUT <= IACK_IN;
      IACK_VECTOR_OUT <= IACK_IN ? irqcfg_r.vector : 8'h00;
      IRQ_ENABLE_OUT <= irqcfg_r.enable;
      IRQ_LEVEL_OUT <= irqcfg_r.level;
      IRQ_ROAK_OUT <= irqcfg_r.roak;
    end
  end

  // ----------------------------------------------------------------
  // Count pulse steering
  // ----------------------------------------------------------------
  logic [CHANNELS-1:0] count_nxt;
  logic [CHANNELS-1:0] key_vec;
  logic [CHANNELS-1:0] p25_vec;

  // Key pulses from logic on this clock; 25 MHz pulse level sampled as a tick
  assign key_vec = {CHANNELS{KEY_TEST_PULSE_IN && ctrl_r.test_mode}};
  assign p25_vec = {CHANNELS{pulse25_s2_r && ctrl_r.pulse25 && ctrl_r.test_mode}} & ~TEST_MASK_IN;

  always_comb
  begin
    count_nxt = (key_vec | p25_vec) & ~INHIBIT_IN;
    // Test mode overrides the reference pulser on channel 1
    if (!ctrl_r.test_mode && ctrl_r.ref_pulser && ref_s2_r && !INHIBIT_IN[0])
      count_nxt[0] = 1'b1;
  end

  always_ff @(posedge CLOCK_IN)
  begin
    if (SRST_IN)
    begin
      COUNT_PULSE_OUT <= '0;
      LED_OUT <= 1'b0;
    end
    else
    begin
      COUNT_PULSE_OUT <= count_nxt;
      LED_OUT <= ctrl_r.led;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_SET_ENABLES: assert property (@(posedge CLOCK_IN) disable iff (SRST_IN)
    (wr_ctrl && WDATA_IN[scrg_pkg::LED_BIT]) |=> ctrl_r.led)
    else $error("LED set did not take");
  AST_CLR_DISABLES: assert property (@(posedge CLOCK_IN) disable iff (SRST_IN)
    (wr_ctrl && !WDATA_IN[0] && WDATA_IN[16]) |=> ##1 !LED_OUT)
    else $error("LED clear did not reach output");
  AST_HOLD: assert property (@(posedge CLOCK_IN) disable iff (SRST_IN)
    !wr_ctrl |=> $stable(ctrl_r))
    else $error("Control changed without write");
  AST_TESTMODE: assert property (@(posedge CLOCK_IN) disable iff (SRST_IN)
    (wr_ctrl && WDATA_IN[5]) |=> ctrl_r.test_mode)
    else $error("Test mode set failed");
  AST_PULSE25: assert property (@(posedge CLOCK_IN) disable iff (SRST_IN)
    (wr_ctrl && !WDATA_IN[4] && WDATA_IN[20]) |=> !ctrl_r.pulse25)
    else $error("Pulse clear failed");
  AST_REFPULSE: assert property (@(posedge CLOCK_IN) disable iff (SRST_IN)
    (wr_ctrl && WDATA_IN[6]) |=> ctrl_r.ref_pulser)
    else $error("Reference set failed");
  AST_STATUS_READ: assert property (@(posedge CLOCK_IN) disable iff (SRST_IN)
    (RD_IN && ADDR_IN == 8'h00) |=> (RDATA_OUT[6:4] == {$past(ctrl_r.ref_pulser),
      $past(ctrl_r.test_mode), $past(ctrl_r.pulse25)}) && RVALID_OUT)
    else $error("Status read mismatch");
  AST_ID_READ: assert property (@(posedge CLOCK_IN) disable iff (SRST_IN)
    (RD_IN && ADDR_IN == 8'h04) |=> RDATA_OUT == {MODULE_ID, MAJOR_REV, MINOR_REV})
    else $error("Ident read mismatch");
  AST_REF_BLOCK: assert property (@(posedge CLOCK_IN) disable iff (SRST_IN)
    (ctrl_r.test_mode && !KEY_TEST_PULSE_IN && !pulse25_s2_r) |=> !COUNT_PULSE_OUT[0])
    else $error("Channel 1 counted outside test pulses");
  AST_KEY_COUNT: assert property (@(posedge CLOCK_IN) disable iff (SRST_IN)
    (KEY_TEST_PULSE_IN && ctrl_r.test_mode) |=> COUNT_PULSE_OUT == ~$past(INHIBIT_IN))
    else $error("Key pulse not counted");
  AST_IACK: assert property (@(posedge CLOCK_IN) disable iff (SRST_IN)
    IACK_IN |=> IACK_VALID_OUT && IACK_VECTOR_OUT == $past(irqcfg_r.vector))
    else $error("Vector not returned");
  AST_RESET_ZERO: assert property (@(posedge CLOCK_IN)
    SRST_IN |=> ctrl_r == '0)
    else $error("Control not cleared by reset");

  // Read positions that carry no status, the clear command bits 20 to 22 among them (bit 16 reads the scaler active flag)
  localparam logic [31:0] STATUS_ZERO_MASK = 32'h047AFF8E;

  AST_LED_FOLLOWS: assert property (@(posedge CLOCK_IN) disable iff (SRST_IN)
    1'b1 |=> LED_OUT == $past(ctrl_r.led))
    else $error("LED output does not follow control");
  AST_STATUS_FLAGS: assert property (@(posedge CLOCK_IN) disable iff (SRST_IN)
    (RD_IN && ADDR_IN == scrg_pkg::CTRL_STATUS_OFS) |=>
      RDATA_OUT[scrg_pkg::SCALER_ACT_BIT] == $past(SCALER_ACTIVE_IN) &&
      RDATA_OUT[scrg_pkg::MCS_ACT_BIT] == $past(MCS_ACTIVE_IN) &&
      RDATA_OUT[scrg_pkg::MEMTEST_BIT] == $past(MEMTEST_IN) &&
      RDATA_OUT[scrg_pkg::ARMED_BIT] == $past(ARMED_IN) &&
      RDATA_OUT[scrg_pkg::HISTO_BIT] == $past(HISTOGRAM_SCALER_OPERATION_IN) &&
      RDATA_OUT[scrg_pkg::OVERFLOW_BIT] == $past(OVERFLOW_IN))
    else $error("Status flags read mismatch");
  AST_EXT_STATUS: assert property (@(posedge CLOCK_IN) disable iff (SRST_IN)
    (RD_IN && ADDR_IN == scrg_pkg::CTRL_STATUS_OFS) |=>
      RDATA_OUT[scrg_pkg::EXT_IN_LSB +: 2] == $past(ext_in_s2_r) &&
      RDATA_OUT[scrg_pkg::EXT_LATCH_LSB +: 2] == $past(ext_lat_s2_r))
    else $error("External input status mismatch");
  AST_STATUS_ZERO_BITS: assert property (@(posedge CLOCK_IN) disable iff (SRST_IN)
    (RD_IN && ADDR_IN == scrg_pkg::CTRL_STATUS_OFS) |=> (RDATA_OUT & STATUS_ZERO_MASK) == scrg_pkg::READ_ZERO)
    else $error("Status read shows command bits");
  AST_READ_IDLE: assert property (@(posedge CLOCK_IN) disable iff (SRST_IN)
    !RD_IN |=> !RVALID_OUT && RDATA_OUT == scrg_pkg::READ_ZERO)
    else $error("Read data outside a read");
  AST_IRQCFG_WRITE: assert property (@(posedge CLOCK_IN) disable iff (SRST_IN)
    (WR_IN && ADDR_IN == scrg_pkg::IRQ_CONFIG_OFS) |=> irqcfg_r == 13'($past(WDATA_IN)))
    else $error("Interrupt configuration write lost");
  AST_IRQCFG_READ: assert property (@(posedge CLOCK_IN) disable iff (SRST_IN)
    (RD_IN && ADDR_IN == scrg_pkg::IRQ_CONFIG_OFS) |=> RDATA_OUT == {19'h00000, $past(irqcfg_r)})
    else $error("Interrupt configuration read mismatch");
  AST_IRQ_OUTS: assert property (@(posedge CLOCK_IN) disable iff (SRST_IN)
    1'b1 |=> IRQ_ROAK_OUT == $past(irqcfg_r.roak) && IRQ_ENABLE_OUT == $past(irqcfg_r.enable) &&
      IRQ_LEVEL_OUT == $past(irqcfg_r.level))
    else $error("Interrupt configuration outputs mismatch");
  AST_IACK_IDLE: assert property (@(posedge CLOCK_IN) disable iff (SRST_IN)
    !IACK_IN |=> !IACK_VALID_OUT && IACK_VECTOR_OUT == 8'h00)
    else $error("Vector shown without acknowledge");
  AST_INHIBIT: assert property (@(posedge CLOCK_IN) disable iff (SRST_IN)
    1'b1 |=> (COUNT_PULSE_OUT & $past(INHIBIT_IN)) == '0)
    else $error("Inhibited channel counted");
  AST_MASK: assert property (@(posedge CLOCK_IN) disable iff (SRST_IN)
    (pulse25_s2_r && ctrl_r.pulse25 && ctrl_r.test_mode && !KEY_TEST_PULSE_IN) |=>
      (COUNT_PULSE_OUT & $past(TEST_MASK_IN)) == '0 && (~COUNT_PULSE_OUT & ~$past(TEST_MASK_IN) & ~$past(INHIBIT_IN)) == '0)
    else $error("Test pulse mask not applied");
  AST_NEEDS_TEST_MODE: assert property (@(posedge CLOCK_IN) disable iff (SRST_IN)
    !ctrl_r.test_mode |=> COUNT_PULSE_OUT[CHANNELS-1:1] == '0)
    else $error("Channel counted outside test mode");
  AST_REF_COUNTS: assert property (@(posedge CLOCK_IN) disable iff (SRST_IN)
    (!ctrl_r.test_mode && ctrl_r.ref_pulser && ref_s2_r && !INHIBIT_IN[0]) |=> COUNT_PULSE_OUT[0])
    else $error("Reference pulse not counted");

endmodule : scrg_regs
`default_nettype wire

/* scrg_host_model.sv */
// Bus master model that drives the register access port of the scaler
`timescale 1ns/1ps
`default_nettype none
module scrg_host_model (
  // Clock
  input wire logic clk_in,
  // Register access
  output logic [7:0] addr_out,
  output logic wr_out,
  output logic rd_out,
  output logic [31:0] wdata_out,
  input wire logic [31:0] rdata_in,
  input wire logic rvalid_in
);
  initial
  begin
    addr_out = 8'h00;
    wr_out = 1'b0;
    rd_out = 1'b0;
    wdata_out = 32'h00000000;
  end

  // ----------------------------------------------------------------
  // Accesses
  // ----------------------------------------------------------------
  // Callers never set a set bit and its clear bit together
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    addr_out <= a;
    wdata_out <= d;
    wr_out <= 1'b1;
    @(posedge clk_in);
    wr_out <= 1'b0;
    // Released lines show the inverse so stale values never look valid
    addr_out <= ~a;
    wdata_out <= ~d;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic ok);
    int i;
    ok = 1'b0;
    d = 32'h00000000;
    @(posedge clk_in);
    addr_out <= a;
    rd_out <= 1'b1;
    @(posedge clk_in);
    rd_out <= 1'b0;
    addr_out <= ~a;
    for (i = 0; i < 3; i++)
    begin
      #1;
      if (rvalid_in === 1'b1)
      begin
        d = rdata_in;
        ok = 1'b1;
        break;
      end
      @(posedge clk_in);
    end
  endtask : rd
endmodule : scrg_host_model
`default_nettype wire

/* test_scrg_regs.sv */
// Self-checking testbench of the scaler control/status registers
`timescale 1ns/1ps
`default_nettype none
module test_scrg_regs;
  localparam logic [15:0] ID = 16'hA5C3; // Arbitrary value
  localparam logic [7:0] MAJ = 8'h2B; // Arbitrary value
  localparam logic [7:0] MIN = 8'h07; // Arbitrary value
  logic clk, srst, wr, rd, iack, rvalid, ivalid, led, key, p25, refp, roak, irqen;
  logic [7:0] addr, ivec;
  logic [31:0] wdata, rdata, inh, msk, cnt;
  logic [5:0] st;
  logic [3:0] ext;
  logic [2:0] lvl;
  logic [31:0] cfg [2];
  int errors, num_checks, i;

  scrg_regs #(.MODULE_ID(ID), .MAJOR_REV(MAJ), .MINOR_REV(MIN), .CHANNELS(32)) u_scrg_regs (
    .CLOCK_IN(clk), .SRST_IN(srst), .ADDR_IN(addr), .WR_IN(wr), .RD_IN(rd), .WDATA_IN(wdata),
    .RDATA_OUT(rdata), .RVALID_OUT(rvalid), .IACK_IN(iack), .IACK_VECTOR_OUT(ivec), .IACK_VALID_OUT(ivalid),
    .SCALER_ACTIVE_IN(st[0]), .MCS_ACTIVE_IN(st[1]), .MEMTEST_IN(st[2]), .ARMED_IN(st[3]),
    .HISTOGRAM_SCALER_OPERATION_IN(st[4]), .OVERFLOW_IN(st[5]), .EXT_INPUT_IN(ext[1:0]),
    .EXT_LATCH_IN(ext[3:2]), .KEY_TEST_PULSE_IN(key), .PULSE25_IN(p25), .REF_PULSE_IN(refp),
    .INHIBIT_IN(inh), .TEST_MASK_IN(msk), .LED_OUT(led), .COUNT_PULSE_OUT(cnt),
    .IRQ_ENABLE_OUT(irqen), .IRQ_LEVEL_OUT(lvl), .IRQ_ROAK_OUT(roak));

  scrg_host_model u_scrg_host_model (.clk_in(clk), .addr_out(addr), .wr_out(wr), .rd_out(rd),
    .wdata_out(wdata), .rdata_in(rdata), .rvalid_in(rvalid));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic final_report();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : final_report

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      errors++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask : chk

  task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic ok;
    u_scrg_host_model.rd(a, d, ok);
    if (ok !== 1'b1)
    begin
      errors++;
      final_report();
    end
    else
      chk(n, e, d);
  endtask : rchk

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : settle

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Hang guard
  initial
  begin
    repeat (5000) @(posedge clk);
    errors++;
    final_report();
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial
  begin
    srst = 1'b1; st = 6'h00; ext = 4'h0; key = 1'b0; p25 = 1'b0; refp = 1'b0; iack = 1'b0;
    inh = 32'hF0F00000; msk = 32'h00000000;
    cfg[0] = 32'hFFFFFB5A; cfg[1] = 32'h000004A5;
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    rchk("ctrl_reset", 8'h00, 32'h00000000);
    rchk("irqcfg_reset", 8'h08, 32'h00000000);
    for (i = 0; i < 4; i++)
    begin
      u_scrg_host_model.wr(8'h00, 32'h1 << (i == 0 ? 0 : i + 3));
      rchk("set", 8'h00, 32'h1 << (i == 0 ? 0 : i + 3));
      u_scrg_host_model.wr(8'h00, 32'h00000000);
      rchk("keep", 8'h00, 32'h1 << (i == 0 ? 0 : i + 3));
      u_scrg_host_model.wr(8'h00, 32'h1 << (i == 0 ? 16 : i + 19));
      rchk("clear", 8'h00, 32'h00000000);
    end
    u_scrg_host_model.wr(8'h00, 32'h00000001);
    settle(1);
    chk("led", 32'h1, {31'h0, led});
    @(posedge clk);
    st <= 6'h3F;
    ext <= 4'h6;
    settle(4);
    rchk("status", 8'h00, 32'h6B850001);
    rchk("ident", 8'h04, {ID, MAJ, MIN});
    u_scrg_host_model.wr(8'h04, 32'hFFFFFFFF);
    rchk("ident_ro", 8'h04, {ID, MAJ, MIN});
    rchk("unmapped", 8'h10, 32'h00000000);
    for (i = 0; i < 2; i++)
    begin
      u_scrg_host_model.wr(8'h08, cfg[i]);
      rchk("irqcfg", 8'h08, cfg[i] & 32'h00001FFF);
      chk("irq_out", {27'h0, cfg[i][12:8]}, {27'h0, roak, irqen, lvl});
      @(posedge clk);
      iack <= 1'b1;
      @(posedge clk);
      iack <= 1'b0;
      #1;
      chk("iack", {23'h0, 1'b1, cfg[i][7:0]}, {23'h0, ivalid, ivec});
    end
    u_scrg_host_model.wr(8'h00, 32'h00710000);
    u_scrg_host_model.wr(8'h00, 32'h00000020);
    @(posedge clk);
    key <= 1'b1;
    @(posedge clk);
    key <= 1'b0;
    #1;
    chk("key_count", ~inh, cnt);
    u_scrg_host_model.wr(8'h00, 32'h00000010);
    @(posedge clk);
    msk <= 32'h0000FF00;
    p25 <= 1'b1;
    settle(5);
    chk("p25_count", ~inh & ~msk, cnt);
    u_scrg_host_model.wr(8'h00, 32'h00200000);
    settle(5);
    chk("p25_no_test", 32'h0, cnt);
    u_scrg_host_model.wr(8'h00, 32'h00000040);
    @(posedge clk);
    p25 <= 1'b0;
    refp <= 1'b1;
    settle(5);
    chk("ref_count", 32'h1, cnt);
    u_scrg_host_model.wr(8'h00, 32'h00000020);
    settle(5);
    chk("ref_blocked", 32'h0, cnt);
    u_scrg_host_model.wr(8'h00, 32'h00000071);
    rchk("ctrl_all_on", 8'h00, 32'h6B850071);
    @(posedge clk);
    srst <= 1'b1;
    st <= 6'h00;
    ext <= 4'h0;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    rchk("ctrl_mid_reset", 8'h00, 32'h00000000);
    chk("led_mid_reset", 32'h0, {31'h0, led});
    rchk("irqcfg_mid_reset", 8'h08, 32'h00000000);
    final_report();
  end
endmodule : test_scrg_regs
`default_nettype wire
